// [psf_regs.svh]
// Register map, field positions, reset values and frame geometry of the channel framer
`ifndef PSF_REGS_SVH
`define PSF_REGS_SVH

// Register byte offsets, low address byte
`define PSF_CTRL_OFS 8'h00
`define PSF_FAULT_OFS 8'h04
`define PSF_SUPV_OFS 8'h08
`define PSF_STAT_OFS 8'h0C

// Writable bits and reset values
`define PSF_CTRL_MASK 8'h0F
`define PSF_FAULT_MASK 8'h07
`define PSF_SUPV_MASK 8'h0F
`define PSF_STAT_W1C_MASK 8'h0E
`define PSF_CTRL_RST 8'h00
`define PSF_FAULT_RST 8'h00
`define PSF_SUPV_RST 8'h0F

// Field positions
`define PSF_CTRL_MODE_LSB 0
`define PSF_CTRL_NEAR_LB 2
`define PSF_CTRL_FAR_LB 3
`define PSF_FAULT_A1A2 0
`define PSF_FAULT_B1 1
`define PSF_FAULT_K2 2
`define PSF_SUPV_B1 0
`define PSF_SUPV_OOF 1
`define PSF_SUPV_RDI 2
`define PSF_SUPV_AIS 3
`define PSF_STAT_INF 0
`define PSF_STAT_OOF 1
`define PSF_STAT_B1 2
`define PSF_STAT_RDI 3

// Overhead byte values
`define PSF_A1 8'hF6
`define PSF_A2 8'h28
`define PSF_J0 8'h01
`define PSF_K2_RDI 8'h06
`define PSF_RDI_CODE 3'h6
`define PSF_SCR_SEED 7'h7F

// Frame geometry in 32-bit words
`define PSF_BYTES_PER_WORD 4
`define PSF_TOH_BYTES 144
`define PSF_TOH_WORDS (`PSF_TOH_BYTES / `PSF_BYTES_PER_WORD)
`define PSF_A1_WORDS 12
`define PSF_A2_END 24
`define PSF_SOH_ROWS 3
`define PSF_B1_ROW 1
`define PSF_B1_WORD 0
`define PSF_K2_ROW 4
`define PSF_K2_WORD 24
`define PSF_ROWS 9
`define PSF_ROW_WORDS 1080

// Framing hysteresis in frames
`define PSF_INF_GOOD 2
`define PSF_OOF_BAD 4

// Core clock period
`define PSF_CLK_PERIOD_NS 5

`endif

// [psf_pkg.sv]
// Types shared by the channel framer modules
package psf_pkg;

	typedef enum logic [1:0]
	{
		psf_serdes_only = 2'h0,
		psf_transparent = 2'h1,
		psf_auto_section_overhead_mode = 2'h2,
		psf_auto_transport_overhead_mode = 2'h3
	} psf_mode_t;

	typedef enum logic [1:0]
	{
		psf_hunt = 2'h0,
		psf_presync = 2'h1,
		psf_sync = 2'h3
	} psf_frm_t;

	typedef struct packed
	{
		logic [7:0] ctrl;
		logic [7:0] fault;
		logic [7:0] supv;
		logic [7:0] stat;
		logic [2:0] fault_act;
		logic dp_wr;
		logic [7:0] dp_addr;
		logic [31:0] hrdata;
		logic [1:0] wph;
		logic [3:0] trow;
		logic [10:0] tcol;
		logic [7:0] tbip;
		logic [7:0] b1_hold;
		logic [31:0] tx_word;
		logic [7:0] line_tx;
		logic [1:0] rlane;
		logic [3:0] rrow;
		logic [10:0] rcol;
		psf_frm_t frm;
		logic [2:0] fcnt;
		logic [7:0] rbip;
		logic [7:0] b1_exp;
		logic b1_valid;
		logic [31:0] rx_data;
		logic rx_valid;
		logic rx_fs;
		logic oof_alarm;
	} psf_state_t;

	typedef struct packed
	{
		logic [7:0] tx_byte;
		logic [23:0] tx_sh;
		logic [31:0] rx_sr;
	} psf_gear_t;

	typedef struct packed
	{
		logic [6:0] lfsr;
	} psf_scr_t;

endpackage

// [psf_lane_if.sv]
// Byte lane signals between the framer core and its width converter
`timescale 1ns/1ps
`default_nettype none

interface psf_lane_if;
	logic tx_load;
	logic [31:0] tx_word;
	logic [7:0] tx_byte;
	logic [7:0] rx_byte;
	logic [31:0] rx_sr;

	modport framer
	(
		output tx_load,
		output tx_word,
		output rx_byte,
		input tx_byte,
		input rx_sr
	);

	modport gear
	(
		input tx_load,
		input tx_word,
		input rx_byte,
		output tx_byte,
		output rx_sr
	);
endinterface // psf_lane_if

`default_nettype wire

// [psf_scrambler.sv]
// Frame-synchronous 1+x^6+x^7 keystream generator, 32 bits per step
`timescale 1ns/1ps
`default_nettype none
`include "psf_regs.svh"

module psf_scrambler
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic seed,
	input wire logic adv,
	output logic [31:0] key
);

	psf_pkg::psf_scr_t st_q;
	psf_pkg::psf_scr_t st_d;
	logic [38:0] res;

	// Returns {next state, 32 key bits}, first bit in the MSB
	function automatic logic [38:0] step32(input logic [6:0] s_in);
		logic [6:0] s;
		logic [31:0] k;
		s = s_in;
		k = 32'h0000_0000;
		for (int i = 0; i < 32; i++)
		begin
			k[31 - i] = s[6];
			s = {s[5:0], s[6] ^ s[5]};
		end
		return {s, k};
	endfunction

	always_comb
	begin
		st_d = st_q;
		res = step32(seed ? `PSF_SCR_SEED : st_q.lfsr);
		key = res[31:0];
		if (seed || adv)
			st_d.lfsr = res[38:32];
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			st_q <= '0;
		else
			st_q <= st_d;
	end

endmodule // psf_scrambler

`default_nettype wire

// [psf_gearbox.sv]
// 32:8 transmit narrowing and 8:32 receive widening
`timescale 1ns/1ps
`default_nettype none

module psf_gearbox
(
	input wire logic clock,
	input wire logic rst_n,
	psf_lane_if.gear lane
);

	psf_pkg::psf_gear_t st_q;
	psf_pkg::psf_gear_t st_d;

	always_comb
	begin
		st_d = st_q;
		// Most significant byte leaves first
		if (lane.tx_load)
		begin
			st_d.tx_byte = lane.tx_word[31:24];
			st_d.tx_sh = lane.tx_word[23:0];
		end
		else
		begin
			st_d.tx_byte = st_q.tx_sh[23:16];
			st_d.tx_sh = {st_q.tx_sh[15:0], 8'h00};
		end
		st_d.rx_sr = {st_q.rx_sr[23:0], lane.rx_byte};
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign lane.tx_byte = st_q.tx_byte;
	assign lane.rx_sr = st_q.rx_sr;

endmodule // psf_gearbox

`default_nettype wire

// [psf_channel_framer.sv]
// Pseudo-SONET channel framer: overhead, fault injection, scrambling, framing, supervision, registers
// Contract
// - Transmit handles 144 overhead bytes, 48 groups of three, at each row start.
// - Two automatic modes generate section or full transport overhead internally.
// - Transparent mode passes every overhead byte from fabric, unscrambled in the first row only.
// - Framing fault control inverts A1 and A2 bytes.
// - Parity fault control inverts the outgoing B1 byte.
// - K2 fault control forces K2 to 00000110.
// - Receiver detects framing, parity and K2 faults and sets alarm status.
// - Receive data leaves as frame-aligned 32-bit words of four bytes.
// - Receive frame start pulse lasts exactly one word beat.
// - Framer tracks in-frame state and raises an alarm entering out-of-frame.
// - Outgoing data scrambled with 1+x^6+x^7, frame synchronous.
// - Incoming data descrambled with the same seven-stage polynomial.
// - Serializer side carries bytes at one eighth of the bit rate.
// - Four bytes per fabric word; word rate is a quarter of byte rate.
// - Fabric word clock lies between 18.75 and 84.38 MHz by lane rate.
// - Each channel's transmit and receive paths run independently.
// - Near-end and far-end loopbacks selected by control register bits.
// - Configuration through a register slave port, readable and writable.
// - Transmit word scrambled before being split into bytes.
// - Parity, out-of-frame, remote defect checks and AIS insertion each enabled.
`timescale 1ns/1ps
`default_nettype none
`include "psf_regs.svh"

module psf_channel_framer
#(
	parameter int unsigned ROW_WORDS = `PSF_ROW_WORDS
)
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [31:0] tx_data,
	output logic tx_word_ready,
	output logic tx_frame_start,
	output logic [7:0] line_tx_byte,
	input wire logic [7:0] line_rx_byte,
	output logic [31:0] rx_data,
	output logic rx_valid,
	output logic rx_frame_start,
	output logic rx_in_frame,
	output logic oof_alarm
);

	psf_pkg::psf_state_t st_q;
	psf_pkg::psf_state_t st_d;
	psf_pkg::psf_mode_t mode;
	psf_lane_if lane();
	logic ahb_ap;
	logic [7:0] rdata;
	logic [31:0] tw;
	logic [31:0] rw;
	logic [31:0] rd;
	logic [31:0] tx_key;
	logic [31:0] rx_key;
	logic tx_toh;
	logic tx_row0;
	logic tx_auto;
	logic tx_b1_pos;
	logic tx_k2_pos;
	logic tx_seed;
	logic tx_adv;
	logic rx_done;
	logic rx_toh0;
	logic rx_seed;
	logic rx_adv;
	logic rx_det;
	logic rx_exp;
	logic in_frame;
	logic sonet;

	function automatic logic [7:0] fold(input logic [31:0] w);
		return w[31:24] ^ w[23:16] ^ w[15:8] ^ w[7:0];
	endfunction

	function automatic logic is_last(input logic [3:0] row, input logic [10:0] col);
		return (row == 4'(`PSF_ROWS - 1)) && (col == 11'(ROW_WORDS - 1));
	endfunction

	function automatic logic [14:0] next_pos(input logic [3:0] row, input logic [10:0] col);
		logic [14:0] p;
		p = {row, col + 11'h001};
		if (col == 11'(ROW_WORDS - 1))
		begin
			p[10:0] = 11'h000;
			p[14:11] = (row == 4'(`PSF_ROWS - 1)) ? 4'h0 : row + 4'h1;
		end
		return p;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Submodules

	psf_gearbox u_gear
	(
		.clock(clock),
		.rst_n(rst_n),
		.lane(lane.gear)
	);

	psf_scrambler u_tx_scr
	(
		.clock(clock),
		.rst_n(rst_n),
		.seed(tx_seed),
		.adv(tx_adv),
		.key(tx_key)
	);

	psf_scrambler u_rx_scr
	(
		.clock(clock),
		.rst_n(rst_n),
		.seed(rx_seed),
		.adv(rx_adv),
		.key(rx_key)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Position decode

	assign mode = psf_pkg::psf_mode_t'(st_q.ctrl[`PSF_CTRL_MODE_LSB +: 2]);
	assign sonet = (mode != psf_pkg::psf_serdes_only);
	assign in_frame = (st_q.frm == psf_pkg::psf_sync);
	// One word per four byte clocks on each side of the gearbox
	assign tx_word_ready = (st_q.wph == 2'h3);
	assign tx_frame_start = tx_word_ready && (st_q.trow == 4'h0) && (st_q.tcol == 11'h000);
	assign tx_toh = (st_q.tcol < 11'(`PSF_TOH_WORDS));
	assign tx_row0 = (st_q.trow == 4'h0);
	assign tx_auto = (mode == psf_pkg::psf_auto_transport_overhead_mode)
		|| ((mode == psf_pkg::psf_auto_section_overhead_mode) && (st_q.trow < 4'(`PSF_SOH_ROWS)));
	assign tx_b1_pos = (st_q.trow == 4'(`PSF_B1_ROW)) && (st_q.tcol == 11'(`PSF_B1_WORD));
	assign tx_k2_pos = (st_q.trow == 4'(`PSF_K2_ROW)) && (st_q.tcol == 11'(`PSF_K2_WORD));
	assign tx_seed = tx_word_ready && sonet && tx_row0 && (st_q.tcol == 11'(`PSF_TOH_WORDS));
	assign tx_adv = tx_word_ready && sonet && !(tx_row0 && tx_toh);
	assign rx_done = (st_q.rlane == 2'h3);
	assign rx_toh0 = (st_q.rrow == 4'h0) && (st_q.rcol < 11'(`PSF_TOH_WORDS));
	assign rx_seed = rx_done && sonet && (st_q.rrow == 4'h0) && (st_q.rcol == 11'(`PSF_TOH_WORDS));
	assign rx_adv = rx_done && sonet && !rx_toh0;
	assign rx_det = (lane.rx_sr[15:8] == `PSF_A1) && (lane.rx_sr[7:0] == `PSF_A2);
	assign rx_exp = (st_q.rrow == 4'h0) && (st_q.rcol == 11'(`PSF_A1_WORDS)) && (st_q.rlane == 2'h0);
	assign ahb_ap = hsel && htrans[1] && hready;

	assign lane.tx_load = (st_q.wph == 2'h0);
	assign lane.tx_word = st_q.tx_word;
	assign lane.rx_byte = st_q.ctrl[`PSF_CTRL_NEAR_LB] ? lane.tx_byte : line_rx_byte;

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb
	begin
		st_d = st_q;
		tw = tx_data;
		rw = lane.rx_sr;
		rd = lane.rx_sr;
		rdata = 8'h00;

		// Bus write data phase; status bits clear on writing one
		if (st_q.dp_wr)
		begin
			case (st_q.dp_addr)
				`PSF_CTRL_OFS: st_d.ctrl = hwdata[7:0] & `PSF_CTRL_MASK;
				`PSF_FAULT_OFS: st_d.fault = hwdata[7:0] & `PSF_FAULT_MASK;
				`PSF_SUPV_OFS: st_d.supv = hwdata[7:0] & `PSF_SUPV_MASK;
				`PSF_STAT_OFS: st_d.stat = st_q.stat & ~(hwdata[7:0] & `PSF_STAT_W1C_MASK);
				default: ;
			endcase
		end
		case (haddr[7:0])
			`PSF_CTRL_OFS: rdata = st_q.ctrl;
			`PSF_FAULT_OFS: rdata = st_q.fault;
			`PSF_SUPV_OFS: rdata = st_q.supv;
			`PSF_STAT_OFS: rdata = {st_q.stat[7:1], in_frame};
			default: rdata = 8'h00;
		endcase
		st_d.dp_wr = ahb_ap && hwrite && (hsize == 3'h2);
		st_d.dp_addr = haddr[7:0];
		if (ahb_ap && !hwrite)
			st_d.hrdata = {24'h00_0000, rdata};

		// Transmit word path
		st_d.wph = st_q.wph + 2'h1;
		st_d.line_tx = st_q.ctrl[`PSF_CTRL_FAR_LB] ? line_rx_byte : lane.tx_byte;
		if (tx_word_ready)
		begin
			if (sonet)
			begin
				if (tx_toh)
				begin
					if (tx_auto)
					begin
						tw = 32'h0000_0000;
						if (tx_row0 && (st_q.tcol < 11'(`PSF_A1_WORDS)))
							tw = {4{`PSF_A1}};
						else if (tx_row0 && (st_q.tcol < 11'(`PSF_A2_END)))
							tw = {4{`PSF_A2}};
						else if (tx_row0 && (st_q.tcol == 11'(`PSF_A2_END)))
							tw[31:24] = `PSF_J0;
						else if (tx_b1_pos)
							tw[31:24] = st_q.b1_hold;
					end
					if (st_q.fault_act[`PSF_FAULT_A1A2] && tx_row0 && (st_q.tcol < 11'(`PSF_A2_END)))
						tw = ~tw;
					if (st_q.fault_act[`PSF_FAULT_B1] && tx_b1_pos)
						tw[31:24] = ~tw[31:24];
					if (st_q.fault_act[`PSF_FAULT_K2] && tx_k2_pos)
						tw[31:24] = `PSF_K2_RDI;
				end
				// First-row overhead carries the framing pattern in clear
				if (!(tx_row0 && tx_toh))
					tw = tw ^ tx_key;
			end
			st_d.tx_word = tw;
			if (is_last(st_q.trow, st_q.tcol))
			begin
				// Parity of the scrambled frame goes into the next frame
				st_d.b1_hold = st_q.tbip ^ fold(tw);
				st_d.tbip = 8'h00;
				st_d.fault_act = st_q.fault[2:0];
			end
			else
				st_d.tbip = st_q.tbip ^ fold(tw);
			{st_d.trow, st_d.tcol} = next_pos(st_q.trow, st_q.tcol);
		end

		// Receive framing, independent of transmit timing
		st_d.rx_valid = 1'b0;
		st_d.rx_fs = 1'b0;
		st_d.oof_alarm = 1'b0;
		st_d.rlane = st_q.rlane + 2'h1;
		if (rx_done)
			{st_d.rrow, st_d.rcol} = next_pos(st_q.rrow, st_q.rcol);
		if (!sonet)
		begin
			st_d.frm = psf_pkg::psf_hunt;
			st_d.fcnt = 3'h0;
		end
		else
		begin
			case (st_q.frm)
				psf_pkg::psf_hunt:
				begin
					if (rx_det)
					begin
						st_d.frm = psf_pkg::psf_presync;
						st_d.fcnt = 3'h1;
						{st_d.rrow, st_d.rcol, st_d.rlane} = {4'h0, 11'(`PSF_A1_WORDS), 2'h1};
					end
				end
				psf_pkg::psf_presync:
				begin
					if (rx_exp && !rx_det)
						st_d.frm = psf_pkg::psf_hunt;
					else if (rx_exp && (st_q.fcnt + 3'h1 == 3'(`PSF_INF_GOOD)))
					begin
						st_d.frm = psf_pkg::psf_sync;
						st_d.fcnt = 3'h0;
					end
					else if (rx_exp)
						st_d.fcnt = st_q.fcnt + 3'h1;
				end
				psf_pkg::psf_sync:
				begin
					if (rx_exp && rx_det)
						st_d.fcnt = 3'h0;
					else if (rx_exp && (st_q.fcnt + 3'h1 == 3'(`PSF_OOF_BAD)))
					begin
						st_d.frm = psf_pkg::psf_hunt;
						st_d.fcnt = 3'h0;
						if (st_q.supv[`PSF_SUPV_OOF])
						begin
							st_d.oof_alarm = 1'b1;
							st_d.stat[`PSF_STAT_OOF] = 1'b1;
						end
					end
					else if (rx_exp)
						st_d.fcnt = st_q.fcnt + 3'h1;
				end
				default: st_d.frm = psf_pkg::psf_hunt;
			endcase
		end

		// Receive word delivery and supervision
		if (rx_done)
		begin
			if (sonet && !rx_toh0)
				rd = rw ^ rx_key;
			st_d.rx_valid = 1'b1;
			st_d.rx_data = (sonet && !in_frame && st_q.supv[`PSF_SUPV_AIS]) ? 32'hFFFF_FFFF : rd;
			st_d.rx_fs = sonet && in_frame && (st_q.rrow == 4'h0) && (st_q.rcol == 11'h000);
			if (is_last(st_q.rrow, st_q.rcol))
			begin
				st_d.b1_exp = st_q.rbip ^ fold(rw);
				st_d.rbip = 8'h00;
				st_d.b1_valid = in_frame;
			end
			else
				st_d.rbip = st_q.rbip ^ fold(rw);
			if (in_frame && st_q.b1_valid && st_q.supv[`PSF_SUPV_B1] && (st_q.rrow == 4'(`PSF_B1_ROW))
				&& (st_q.rcol == 11'(`PSF_B1_WORD)) && (rd[31:24] != st_q.b1_exp))
				st_d.stat[`PSF_STAT_B1] = 1'b1;
			if (in_frame && st_q.supv[`PSF_SUPV_RDI] && (st_q.rrow == 4'(`PSF_K2_ROW))
				&& (st_q.rcol == 11'(`PSF_K2_WORD)) && (rd[26:24] == `PSF_RDI_CODE))
				st_d.stat[`PSF_STAT_RDI] = 1'b1;
		end
		// Parity reference is only trusted when the frame it covers ends in sync
		if (st_d.frm != psf_pkg::psf_sync)
			st_d.b1_valid = 1'b0;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_q <= '0;
			st_q.supv <= `PSF_SUPV_RST;
		end
		else
			st_q <= st_d;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign hrdata = st_q.hrdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign line_tx_byte = st_q.line_tx;
	assign rx_data = st_q.rx_data;
	assign rx_valid = st_q.rx_valid;
	assign rx_frame_start = st_q.rx_fs;
	assign rx_in_frame = in_frame;
	assign oof_alarm = st_q.oof_alarm;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	AST_AUTO_A1: assert property ((tx_word_ready && tx_auto && tx_row0 && (st_q.tcol < 11'(`PSF_A1_WORDS))
		&& !st_q.fault_act[`PSF_FAULT_A1A2]) |=> (st_q.tx_word == {4{`PSF_A1}}))
		else $error("auto overhead A1 word wrong");
	AST_TRANSP: assert property ((tx_word_ready && (mode == psf_pkg::psf_transparent) && tx_row0 && tx_toh
		&& !st_q.fault_act[`PSF_FAULT_A1A2]) |=> (st_q.tx_word == $past(tx_data)))
		else $error("transparent overhead altered");
	AST_A1_INV: assert property ((tx_word_ready && tx_auto && tx_row0 && (st_q.tcol < 11'(`PSF_A1_WORDS))
		&& st_q.fault_act[`PSF_FAULT_A1A2]) |=> (st_q.tx_word == ~{4{`PSF_A1}}))
		else $error("A1 not inverted");
	AST_B1_INV: assert property ((tx_word_ready && tx_auto && tx_b1_pos && st_q.fault_act[`PSF_FAULT_B1])
		|=> ((st_q.tx_word[31:24] ^ $past(tx_key[31:24])) == ~$past(st_q.b1_hold)))
		else $error("B1 not inverted");
	AST_K2: assert property ((tx_word_ready && sonet && tx_k2_pos && st_q.fault_act[`PSF_FAULT_K2])
		|=> ((st_q.tx_word[31:24] ^ $past(tx_key[31:24])) == `PSF_K2_RDI))
		else $error("K2 fault pattern missing");
	AST_SCRAMBLE: assert property ((tx_word_ready && (mode == psf_pkg::psf_transparent) && !tx_toh)
		|=> (st_q.tx_word == ($past(tx_data) ^ $past(tx_key))))
		else $error("payload not scrambled");
	AST_RESEED: assert property ((tx_word_ready && (mode == psf_pkg::psf_transparent) && tx_row0
		&& (st_q.tcol == 11'(`PSF_TOH_WORDS))) |=> (st_q.tx_word == ($past(tx_data) ^ 32'hFE04_1851)))
		else $error("keystream not reseeded at frame start");
	AST_BYPASS: assert property ((tx_word_ready && !sonet) |=> (st_q.tx_word == $past(tx_data)))
		else $error("bypass word altered");
	AST_WORD_RATE: assert property (tx_word_ready |=> !tx_word_ready [*3] ##1 tx_word_ready)
		else $error("word rate not a quarter of byte rate");
	AST_RX_BEAT: assert property ((rx_valid && (st_q.frm != psf_pkg::psf_hunt) && !rx_exp)
		|=> !rx_valid [*3] ##1 rx_valid)
		else $error("receive word spacing wrong");
	AST_FS_ONE: assert property (rx_frame_start |-> (rx_valid && in_frame) ##1 !rx_frame_start)
		else $error("frame start pulse malformed");
	AST_OOF: assert property ((st_q.frm == psf_pkg::psf_hunt && $past(st_q.frm) == psf_pkg::psf_sync
		&& $past(st_q.supv[`PSF_SUPV_OOF]) && $past(sonet)) |-> oof_alarm)
		else $error("out-of-frame entry without alarm");
	AST_OOF_STICKY: assert property (oof_alarm |-> st_q.stat[`PSF_STAT_OOF])
		else $error("out-of-frame status not set");
	AST_NEAR_LB: assert property ((st_q.ctrl[`PSF_CTRL_NEAR_LB]) |=> (lane.rx_sr[7:0] == $past(lane.tx_byte)))
		else $error("near loopback byte lost");

	CV_SYNC: cover property (st_q.frm == psf_pkg::psf_presync ##[1:1000] in_frame);
	CV_OOF: cover property (oof_alarm);
	CV_B1: cover property ($rose(st_q.stat[`PSF_STAT_B1]));
	CV_RDI: cover property ($rose(st_q.stat[`PSF_STAT_RDI]));

endmodule // psf_channel_framer

`default_nettype wire

// [psf_far_end.sv]
// Far-end transceiver model: returns the line stream after a few byte times
`timescale 1ns/1ps
`default_nettype none
module psf_far_end
#(
	parameter int DLY = 3
)
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic corrupt,
	input wire logic [7:0] line_in,
	output logic [7:0] line_out
);
	// Odd byte delay, so the receiver must find the word boundary itself
	logic [8 * DLY - 1:0] pipe_q;
	////////////////////////////////////////
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			pipe_q <= {DLY{8'h5A}};
		else
			pipe_q <= {pipe_q[8 * DLY - 9:0], line_in};
	end
	// A broken line shows inverted bytes, not a stuck level
	assign line_out = pipe_q[8 * DLY - 1 -: 8] ^ {8{corrupt}};
endmodule // psf_far_end
`default_nettype wire

// [psf_channel_framer_bench.sv]
// Self-checking bench of the channel framer with a far-end echo
`timescale 1ns/1ps
`default_nettype none
`include "psf_regs.svh"
module psf_channel_framer_bench;
	localparam int RW = 40;
	localparam int FR = 9 * RW;
	localparam int FC = FR * 4;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] tx_data = 32'h0000_0000;
	logic corrupt = 1'b0, ser_chk = 1'b0, far_chk = 1'b0, rx_chk = 1'b0, rok = 1'b0, a1_on = 1'b0, a1_frm = 1'b0;
	logic hreadyout, hresp, tx_word_ready, tx_frame_start, rx_valid, rx_frame_start, rx_in_frame, oof_alarm;
	logic [31:0] hrdata, rx_data, rd, seed;
	logic [7:0] line_tx_byte, line_rx_byte, rx_prev, ad;
	logic [31:0] tx_frame [FR];
	logic [39:0] bq [$];
	int err_count = 0, n_tests = 0, cyc = 0, tpos = 0, rpos = 0, mode = 0, oofs = 0;
	////////////////////////////////////////
	always #2.5 clock = ~clock;
	psf_channel_framer #(.ROW_WORDS(RW)) i_dut (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .tx_data(tx_data), .tx_word_ready(tx_word_ready),
		.tx_frame_start(tx_frame_start), .line_tx_byte(line_tx_byte), .line_rx_byte(line_rx_byte), .rx_data(rx_data),
		.rx_valid(rx_valid), .rx_frame_start(rx_frame_start), .rx_in_frame(rx_in_frame), .oof_alarm(oof_alarm));
	psf_far_end i_far (.clock(clock), .rst_n(rst_n), .corrupt(corrupt), .line_in(line_tx_byte), .line_out(line_rx_byte));
	////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_sim;
		if (err_count == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0000_0000);
	endfunction
	function automatic logic [7:0] wmask(input logic [7:0] a);
		case (a)
			`PSF_CTRL_OFS: return `PSF_CTRL_MASK;
			`PSF_FAULT_OFS: return `PSF_FAULT_MASK;
			`PSF_SUPV_OFS: return `PSF_SUPV_MASK;
			default: return 8'h00;
		endcase
	endfunction
	task automatic wait_rdy;
		@(posedge clock);
		for (int n = 0; n < 50 && hreadyout !== 1'b1; n++)
			@(posedge clock);
		if (hreadyout !== 1'b1)
		begin
			err_count++;
			end_sim;
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [2:0] sz);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= sz;
		wait_rdy;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy;
		rd = hrdata;
	endtask
	task automatic rdreg(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000, 3'h2);
		chk(rd, e);
		chk(hresp, 1'b0);
	endtask
	// Lets a stale lock drop first, so payload checks start on a fresh alignment
	task automatic wsync;
		for (int n = 0; n < 6 * FC && rx_in_frame === 1'b1; n++)
			@(posedge clock);
		for (int n = 0; n < 10 * FC && rx_in_frame !== 1'b1; n++)
			@(posedge clock);
		chk(rx_in_frame, 1'b1);
		if (rx_in_frame !== 1'b1)
			end_sim;
	endtask
	always @(posedge clock)
	begin
		cyc++;
		if (tx_word_ready === 1'b1)
		begin
			if (mode != 0)
				chk(tx_frame_start, tpos == 0);
			if (tx_frame_start === 1'b1)
				tpos = 0;
			// Fault bits latch with the last word, so this flag belongs to the next frame
			if (tpos == FR - 1)
				a1_frm = a1_on;
			for (int i = 0; i < 4 && ser_chk; i++)
				bq.push_back({cyc + 3 + i, tx_frame[tpos][31 - 8 * i -: 8]});
			tpos = (tpos + 1) % FR;
			tx_data <= tx_frame[tpos];
		end
		if (bq.size() > 0 && bq[0][39:8] == cyc)
		begin
			chk(line_tx_byte, bq[0][7:0]);
			bq.delete(0);
		end
		if (far_chk)
			chk(line_tx_byte, rx_prev);
		rx_prev = line_rx_byte;
		if (rx_in_frame !== 1'b1)
			rok = 1'b0;
		if (rx_frame_start === 1'b1)
		begin
			chk(rx_valid, 1'b1);
			if (rx_chk)
				chk(rx_data, a1_frm ? 32'h0909_0909 : 32'hF6F6_F6F6);
			rpos = 0;
			rok = 1'b1;
		end
		else if (rx_valid === 1'b1)
		begin
			rpos = (rpos + 1) % FR;
			if (rx_chk && rok && rpos % RW >= 36)
				chk(rx_data, tx_frame[rpos]);
		end
		if (oof_alarm === 1'b1)
			oofs++;
	end
	initial
	begin
		seed = 32'h0000_f29e;
		for (int i = 0; i < FR; i++)
		begin
			seed = lfsr(seed);
			tx_frame[i] = (i < 12) ? 32'hF6F6_F6F6 : (i < 24) ? 32'h2828_2828 : seed;
		end
		tx_data = tx_frame[0];
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		// Five reset reads, then random writes with read-back
		for (int k = 0; k < 15; k++)
		begin
			ad = 8'(4 * (k % 5));
			seed = lfsr(seed);
			if (k < 5)
				rdreg(ad, ad == `PSF_SUPV_OFS ? 32'h0000_000F : 32'h0000_0000);
			else
			begin
				bus(1'b1, ad, seed, 3'h2);
				rdreg(ad, {24'h00_0000, seed[7:0] & wmask(ad)});
			end
		end
		bus(1'b1, `PSF_SUPV_OFS, 32'h0000_000F, 3'h2);
		bus(1'b1, `PSF_SUPV_OFS, 32'h0000_0000, 3'h0);
		rdreg(`PSF_SUPV_OFS, 32'h0000_000F);
		bus(1'b1, `PSF_FAULT_OFS, 32'h0000_0000, 3'h2);
		bus(1'b1, `PSF_CTRL_OFS, 32'h0000_0000, 3'h2);
		ser_chk <= 1'b1;
		repeat (64) @(posedge clock);
		ser_chk <= 1'b0;
		// Queued line bytes must drain before the line path changes
		repeat (8) @(posedge clock);
		bus(1'b1, `PSF_CTRL_OFS, 32'h0000_0008, 3'h2);
		repeat (3) @(posedge clock);
		far_chk <= 1'b1;
		repeat (20) @(posedge clock);
		far_chk <= 1'b0;
		// Transparent mode runs over near loopback with the far line broken
		for (int m = 1; m < 4; m++)
		begin
			rx_chk <= 1'b0;
			corrupt <= (m == 1);
			mode <= m;
			bus(1'b1, `PSF_CTRL_OFS, m == 1 ? 32'h0000_0005 : 32'(m), 3'h2);
			wsync;
			rx_chk <= 1'b1;
			repeat (FC) @(posedge clock);
		end
		bus(1'b1, `PSF_STAT_OFS, 32'h0000_000E, 3'h2);
		repeat (2 * FC) @(posedge clock);
		rdreg(`PSF_STAT_OFS, 32'h0000_0001);
		for (int f = 1; f < 3; f++)
		begin
			bus(1'b1, `PSF_FAULT_OFS, 32'(1 << f), 3'h2);
			repeat (3 * FC) @(posedge clock);
			bus(1'b1, `PSF_FAULT_OFS, 32'h0000_0000, 3'h2);
			repeat (2 * FC) @(posedge clock);
			rdreg(`PSF_STAT_OFS, 32'(1 | (2 << f)));
			bus(1'b1, `PSF_STAT_OFS, 32'h0000_000E, 3'h2);
		end
		oofs = 0;
		bus(1'b1, `PSF_FAULT_OFS, 32'h0000_0001, 3'h2);
		a1_on <= 1'b1;
		for (int n = 0; n < 7 * FC && rx_in_frame === 1'b1; n++)
			@(posedge clock);
		repeat (8) @(posedge clock);
		chk(rx_in_frame, 1'b0);
		chk(oofs, 1);
		chk(rx_data, 32'hFFFF_FFFF);
		bus(1'b0, `PSF_STAT_OFS, 32'h0000_0000, 3'h2);
		chk(rd & 32'h0000_000B, 32'h0000_0002);
		bus(1'b1, `PSF_STAT_OFS, 32'h0000_000E, 3'h2);
		rdreg(`PSF_STAT_OFS, 32'h0000_0000);
		bus(1'b1, `PSF_FAULT_OFS, 32'h0000_0000, 3'h2);
		a1_on <= 1'b0;
		wsync;
		end_sim;
	end
endmodule // psf_channel_framer_bench
`default_nettype wire
